// *** inc/slc_pkg.sv ***
// Behaviour
// - separate instruction and data caches, each 32 KB, eight-way
// - 128 sets of eight ways, set chosen by address bits 20..26
// - 32-byte aligned lines of eight words, bits 27..31 pick the byte
// - instruction line half (128 bits) selected by address bit 27
// - tags hold physical bits 0..19, compared against the selected set
// - victim in a set chosen by pseudo least-recently-used tree
// - data lines carry two state bits: modified, exclusive, invalid
// - instruction lines carry one valid bit and are never snooped
// - each cache invalidated as a whole or locked by config bits
// - 32-bit physical addresses, 4 GB coherent space
// - miss refill is four 64-bit beats, requested double word first
// - load's requested double word stored and forwarded in the same cycle; fetch forwards once its 128 bits are in
// - data refill gathered in reload buffer, written in one cycle
// - two line-wide buffers move a whole line in one cycle
// - a miss asks the level-two cache before the bus
// - stores update only addressed bytes: byte to double word
// - instruction cache delivers 128 bits, four instructions, per access
// - one tag port; snoop miss frees next cycle, hit may hold longer
// - data fills go out as read-with-intent-to-modify, line exclusive
// - snooped global read hit: push modified line, then invalidate
// - snooped inhibited read X1010: push modified to exclusive, no invalidate
package slc_pkg;
  localparam int SETS = 128;
  localparam int WAYS = 8;
  localparam int LINE_W = 256;
  localparam int PA_W = 32;
  localparam int TAG_W = 20;
  localparam int TAG_LSB = 12;
  localparam int IDX_W = 7;
  localparam int IDX_LSB = 5;
  localparam int DW_LSB = 3;
  localparam int QW_BIT = 4;
  localparam logic [3:0] CI_READ_TT = 4'ha;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CFG_IFLUSH = 0;
  localparam int CFG_DFLUSH = 1;
  localparam int CFG_ILOCK = 2;
  localparam int CFG_DLOCK = 3;
  localparam logic CFG_RST = 1'b0;

  typedef logic [LINE_W-1:0] slc_line_t;
  typedef logic [TAG_W-1:0] slc_tag_t;
  typedef logic [IDX_W-1:0] slc_idx_t;
  typedef enum logic [1:0] {
    COH_INVALID = 2'h0, COH_EXCL = 2'h1, COH_MOD = 2'h3
  } slc_coh_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_L2 = 3'h1, ST_FILL = 3'h3, ST_INST = 3'h2,
    ST_SNP = 3'h4
  } slc_state_t;
  typedef struct packed {
    logic vld; logic we; logic [7:0] be;
    logic [PA_W-1:0] ea; logic [PA_W-1:0] pa; logic [63:0] wdat;
  } slc_ls_req_t;
  typedef struct packed {
    logic vld; logic [PA_W-1:0] ea; logic [PA_W-1:0] pa;
  } slc_if_req_t;
  typedef struct packed {
    logic vld; logic glob; logic [4:0] ttype; logic [PA_W-1:0] pa;
  } slc_snp_t;
  typedef struct packed {
    logic vld; logic bus; logic rwitm; logic [PA_W-1:0] adr;
  } slc_nl_req_t;
endpackage

// *** rtl/slc_tree.sv ***
`timescale 1ns/1ns
`default_nettype none
module slc_tree (
  input wire logic [6:0] bits_i,
  input wire logic [7:0] free_i,
  input wire logic [2:0] acc_i,
  output logic [2:0] vic_o,
  output logic [6:0] next_o
);
  logic [2:0] tv;
  // an empty way beats the tree: no point evicting live data
  always_comb begin
    tv[2] = bits_i[0];
    tv[1] = tv[2] ? bits_i[2] : bits_i[1];
    tv[0] = bits_i[3 + {tv[2], tv[1]}];
    for (int w = 7; w >= 0; w--) begin
      if (free_i[w]) begin
        tv = 3'(w);
      end
    end
    vic_o = tv;
  end

  // point every node on the path away from the way just used
  always_comb begin
    next_o = bits_i;
    next_o[0] = ~acc_i[2];
    next_o[1 + acc_i[2]] = ~acc_i[1];
    next_o[3 + acc_i[2:1]] = ~acc_i[0];
  end
endmodule
`default_nettype wire

// *** rtl/slc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module slc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire slc_pkg::slc_ls_req_t ls_req_i,
  output logic ls_ack_o,
  output logic [63:0] ls_rdat_o,
  input wire slc_pkg::slc_if_req_t if_req_i,
  output logic if_ack_o,
  output logic [127:0] if_dat_o,
  input wire slc_pkg::slc_snp_t snp_i,
  output logic snp_done_o,
  output logic snp_hit_o,
  output var slc_pkg::slc_nl_req_t nl_req_o,
  input wire logic l2_hit_i,
  input wire logic l2_miss_i,
  input wire logic fill_vld_i,
  input wire logic [63:0] fill_dat_i,
  output logic cb_vld_o,
  output logic [31:0] cb_adr_o,
  output logic [255:0] cb_dat_o,
  input wire logic cb_rdy_i
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // two arrays of 128 x 8 x 32 bytes
  slc_pkg::slc_line_t dd_q [slc_pkg::SETS][slc_pkg::WAYS];
  slc_pkg::slc_line_t id_q [slc_pkg::SETS][slc_pkg::WAYS];
  slc_pkg::slc_tag_t dt_q [slc_pkg::SETS][slc_pkg::WAYS];
  slc_pkg::slc_tag_t it_q [slc_pkg::SETS][slc_pkg::WAYS];
  slc_pkg::slc_coh_t ds_q [slc_pkg::SETS][slc_pkg::WAYS];
  logic iv_q [slc_pkg::SETS][slc_pkg::WAYS];
  logic [6:0] dp_q [slc_pkg::SETS];
  logic [6:0] ip_q [slc_pkg::SETS];

  slc_pkg::slc_state_t st_q;
  logic mi_q;
  logic mwe_q;
  logic [31:0] mpa_q;
  logic [1:0] cnt_q;
  logic [3:0] bm_q;
  logic fwd_q;
  slc_pkg::slc_line_t rl_q;
  logic fli_q;
  logic fld_q;
  logic ilk_q;
  logic dlk_q;

  function automatic logic [2:0] enc8(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // lane b of the double word lands at byte b of that double word
  function automatic slc_pkg::slc_line_t merge(
    input slc_pkg::slc_line_t l, input logic [1:0] dw,
    input logic [7:0] be, input logic [63:0] d);
    slc_pkg::slc_line_t r;
    r = l;
    for (int b = 0; b < 8; b++) begin
      if (be[b]) begin
        r[{dw, 3'(b), 3'h0} +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  slc_pkg::slc_idx_t ls_set, if_set, sn_set, m_set;
  logic [7:0] ls_hv, if_hv, sn_hv, tr_free;
  logic [2:0] ls_w, if_w, sn_w, vic_w, tr_w;
  logic [6:0] tr_bits, tr_next;
  logic ls_hit, if_hit, sn_hit, sn_ci, sn_dirty;

  assign ls_set = ls_req_i.ea[slc_pkg::IDX_LSB +: slc_pkg::IDX_W];
  assign if_set = if_req_i.ea[slc_pkg::IDX_LSB +: slc_pkg::IDX_W];
  // index bits sit below the page offset, so physical equals effective
  assign sn_set = snp_i.pa[slc_pkg::IDX_LSB +: slc_pkg::IDX_W];
  assign m_set = mpa_q[slc_pkg::IDX_LSB +: slc_pkg::IDX_W];

  for (genvar w = 0; w < slc_pkg::WAYS; w++) begin : g_way
    assign ls_hv[w] = ds_q[ls_set][w] != slc_pkg::COH_INVALID &&
      dt_q[ls_set][w] == ls_req_i.pa[31:slc_pkg::TAG_LSB];
    assign if_hv[w] = iv_q[if_set][w] &&
      it_q[if_set][w] == if_req_i.pa[31:slc_pkg::TAG_LSB];
    assign sn_hv[w] = ds_q[sn_set][w] != slc_pkg::COH_INVALID &&
      dt_q[sn_set][w] == snp_i.pa[31:slc_pkg::TAG_LSB];
    assign tr_free[w] = mi_q ? !iv_q[m_set][w] :
      ds_q[m_set][w] == slc_pkg::COH_INVALID;
  end

  assign ls_w = enc8(ls_hv);
  assign if_w = enc8(if_hv);
  assign sn_w = enc8(sn_hv);
  assign ls_hit = |ls_hv;
  assign if_hit = |if_hv;
  assign sn_hit = |sn_hv && snp_i.glob;
  assign sn_ci = snp_i.ttype[3:0] == slc_pkg::CI_READ_TT;
  assign sn_dirty = ds_q[sn_set][sn_w] == slc_pkg::COH_MOD;

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  logic fl_go, sn_go, ls_go, if_go, idle;
  logic lck, vic_dirty, lck_st, inst_ok, snp_ok, inst_do, cb_ld;
  logic [1:0] f_dw;
  logic [3:0] bm_nx;
  logic if_fwd;
  slc_pkg::slc_line_t rl_nx, cb_line;
  logic [31:0] cb_adr;

  // single tag port: flush first, then snoop, then load/store, then fetch
  always_comb begin
    idle = st_q == slc_pkg::ST_IDLE;
    fl_go = idle && (fli_q || fld_q);
    sn_go = idle && !fl_go && snp_i.vld && !snp_done_o;
    ls_go = idle && !fl_go && !sn_go && ls_req_i.vld && !ls_ack_o;
    if_go = idle && !fl_go && !sn_go && !ls_go && if_req_i.vld &&
      !if_ack_o;
  end

  assign tr_bits = st_q == slc_pkg::ST_INST ?
    (mi_q ? ip_q[m_set] : dp_q[m_set]) :
    (ls_go ? dp_q[ls_set] : ip_q[if_set]);
  assign tr_w = st_q == slc_pkg::ST_INST ? vic_w : (ls_go ? ls_w : if_w);

  slc_tree u_tree (
    .bits_i(tr_bits),
    .free_i(tr_free),
    .acc_i(tr_w),
    .vic_o(vic_w),
    .next_o(tr_next)
  );

  always_comb begin
    lck = mi_q ? ilk_q : dlk_q;
    vic_dirty = !mi_q && !dlk_q &&
      ds_q[m_set][vic_w] == slc_pkg::COH_MOD;
    // a store miss to a locked data cache leaves as a copy-back line
    lck_st = !mi_q && dlk_q && mwe_q;
    inst_ok = !((vic_dirty || lck_st) && cb_vld_o);
    inst_do = st_q == slc_pkg::ST_INST && inst_ok;
    snp_ok = !(sn_dirty && cb_vld_o);
    cb_ld = (inst_do && (vic_dirty || lck_st)) ||
      (st_q == slc_pkg::ST_SNP && snp_ok && sn_dirty);
    f_dw = mpa_q[4:3] + cnt_q;
    bm_nx = bm_q | (4'h1 << f_dw);
    rl_nx = rl_q;
    rl_nx[{f_dw, 6'h0} +: 64] = fill_dat_i;
    if_fwd = mi_q && !fwd_q && bm_nx[{mpa_q[4], 1'b0}] &&
      bm_nx[{mpa_q[4], 1'b1}];
    if (st_q == slc_pkg::ST_SNP) begin
      cb_line = dd_q[sn_set][sn_w];
      cb_adr = {dt_q[sn_set][sn_w], sn_set, 5'h0};
    end else if (lck_st) begin
      cb_line = merge(rl_q, ls_req_i.ea[4:3], ls_req_i.be,
        ls_req_i.wdat);
      cb_adr = {mpa_q[31:5], 5'h0};
    end else begin
      cb_line = dd_q[m_set][vic_w];
      cb_adr = {dt_q[m_set][vic_w], m_set, 5'h0};
    end
  end

  // ---------------------------------------------------------------
  // miss sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= slc_pkg::ST_IDLE;
      mi_q <= 1'b0;
      mwe_q <= 1'b0;
      mpa_q <= 32'h0;
      cnt_q <= 2'h0;
      bm_q <= 4'h0;
      fwd_q <= 1'b0;
      nl_req_o <= '0;
    end else begin
      unique case (st_q)
        slc_pkg::ST_IDLE: begin
          if (sn_go && sn_hit) begin
            st_q <= slc_pkg::ST_SNP;
          end else if ((ls_go && !ls_hit) || (if_go && !if_hit)) begin
            st_q <= slc_pkg::ST_L2;
            mi_q <= !ls_go;
            mwe_q <= ls_go && ls_req_i.we;
            mpa_q <= ls_go ? ls_req_i.pa : if_req_i.pa;
            cnt_q <= 2'h0;
            bm_q <= 4'h0;
            fwd_q <= 1'b0;
            nl_req_o.vld <= 1'b1;
            nl_req_o.bus <= 1'b0;
            nl_req_o.rwitm <= ls_go;
            nl_req_o.adr <= {(ls_go ? ls_req_i.pa[31:3] :
              if_req_i.pa[31:3]), 3'h0};
          end
        end
        slc_pkg::ST_L2: begin
          if (l2_hit_i) begin
            st_q <= slc_pkg::ST_FILL;
          end else if (l2_miss_i) begin
            st_q <= slc_pkg::ST_FILL;
            nl_req_o.bus <= 1'b1;
          end
        end
        slc_pkg::ST_FILL: begin
          if (fill_vld_i) begin
            cnt_q <= cnt_q + 2'h1;
            bm_q <= bm_nx;
            fwd_q <= fwd_q || if_fwd;
            if (cnt_q == 2'h3) begin
              st_q <= slc_pkg::ST_INST;
              nl_req_o.vld <= 1'b0;
            end
          end
        end
        slc_pkg::ST_INST: begin
          if (inst_ok) begin
            st_q <= slc_pkg::ST_IDLE;
          end
        end
        slc_pkg::ST_SNP: begin
          // hit holds the port a second cycle, more if the line is modified and the buffer busy
          if (snp_ok) begin
            st_q <= slc_pkg::ST_IDLE;
          end
        end
        default: st_q <= slc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (st_q == slc_pkg::ST_FILL && fill_vld_i) begin
      rl_q <= rl_nx;
    end
  end

  // ---------------------------------------------------------------
  // arrays
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ls_go && ls_hit && ls_req_i.we) begin
      dd_q[ls_set][ls_w] <= merge(dd_q[ls_set][ls_w], ls_req_i.ea[4:3],
        ls_req_i.be, ls_req_i.wdat);
    end
    if (inst_do && !lck) begin
      if (mi_q) begin
        id_q[m_set][vic_w] <= rl_q;
        it_q[m_set][vic_w] <= mpa_q[31:slc_pkg::TAG_LSB];
      end else begin
        dd_q[m_set][vic_w] <= rl_q;
        dt_q[m_set][vic_w] <= mpa_q[31:slc_pkg::TAG_LSB];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < slc_pkg::SETS; s++) begin
        for (int w = 0; w < slc_pkg::WAYS; w++) begin
          ds_q[s][w] <= slc_pkg::COH_INVALID;
          iv_q[s][w] <= 1'b0;
        end
      end
    end else begin
      // flash clear drops modified data without a copy-back
      for (int s = 0; s < slc_pkg::SETS; s++) begin
        for (int w = 0; w < slc_pkg::WAYS; w++) begin
          if (fl_go && fld_q) begin
            ds_q[s][w] <= slc_pkg::COH_INVALID;
          end
          if (fl_go && fli_q) begin
            iv_q[s][w] <= 1'b0;
          end
        end
      end
      if (ls_go && ls_hit && ls_req_i.we) begin
        ds_q[ls_set][ls_w] <= slc_pkg::COH_MOD;
      end
      if (inst_do && !lck) begin
        if (mi_q) begin
          iv_q[m_set][vic_w] <= 1'b1;
        end else begin
          ds_q[m_set][vic_w] <= slc_pkg::COH_EXCL;
        end
      end
      if (st_q == slc_pkg::ST_SNP && snp_ok) begin
        if (!sn_ci) begin
          ds_q[sn_set][sn_w] <= slc_pkg::COH_INVALID;
        end else if (sn_dirty) begin
          ds_q[sn_set][sn_w] <= slc_pkg::COH_EXCL;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < slc_pkg::SETS; s++) begin
        dp_q[s] <= 7'h0;
        ip_q[s] <= 7'h0;
      end
    end else begin
      if (ls_go && ls_hit) begin
        dp_q[ls_set] <= tr_next;
      end
      if (if_go && if_hit) begin
        ip_q[if_set] <= tr_next;
      end
      if (inst_do && !lck) begin
        if (mi_q) begin
          ip_q[m_set] <= tr_next;
        end else begin
          dp_q[m_set] <= tr_next;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // requester answers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_ack_o <= 1'b0;
      ls_rdat_o <= 64'h0;
    end else begin
      ls_ack_o <= 1'b0;
      if (ls_go && ls_hit) begin
        ls_ack_o <= 1'b1;
        ls_rdat_o <= dd_q[ls_set][ls_w][{ls_req_i.ea[4:3], 6'h0} +: 64];
      end else if (st_q == slc_pkg::ST_FILL && fill_vld_i &&
          cnt_q == 2'h0 && !mi_q && !mwe_q) begin
        ls_ack_o <= 1'b1;
        ls_rdat_o <= fill_dat_i;
      end else if (inst_do && lck_st) begin
        ls_ack_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_ack_o <= 1'b0;
      if_dat_o <= 128'h0;
    end else begin
      if_ack_o <= 1'b0;
      if (if_go && if_hit) begin
        if_ack_o <= 1'b1;
        if_dat_o <= id_q[if_set][if_w][{if_req_i.ea[4], 7'h0} +: 128];
      end else if (st_q == slc_pkg::ST_FILL && fill_vld_i && if_fwd) begin
        if_ack_o <= 1'b1;
        if_dat_o <= rl_nx[{mpa_q[4], 7'h0} +: 128];
      end
    end
  end

  // the snooped address is held by the bus side until done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snp_done_o <= 1'b0;
      snp_hit_o <= 1'b0;
    end else begin
      snp_done_o <= (sn_go && !sn_hit) ||
        (st_q == slc_pkg::ST_SNP && snp_ok);
      snp_hit_o <= st_q == slc_pkg::ST_SNP && snp_ok;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cb_vld_o <= 1'b0;
      cb_adr_o <= 32'h0;
      cb_dat_o <= '0;
    end else if (cb_ld) begin
      cb_vld_o <= 1'b1;
      cb_adr_o <= cb_adr;
      cb_dat_o <= cb_line;
    end else if (cb_rdy_i) begin
      cb_vld_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register slave
  // ---------------------------------------------------------------
  logic wb_go, cfg_wr;
  assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cfg_wr = wb_go && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == slc_pkg::CFG_OFS;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go && !wb_we_i) begin
        if (wb_adr_i == slc_pkg::CFG_OFS) begin
          wb_dat_o <= {28'h0, dlk_q, ilk_q, fld_q, fli_q};
        end else if (wb_adr_i == slc_pkg::STAT_OFS) begin
          wb_dat_o <= {27'h0, cb_vld_o, nl_req_o.vld, st_q};
        end else begin
          wb_dat_o <= 32'h0;
        end
      end
    end
  end

  // flush bits clear themselves once applied; a new write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fli_q <= slc_pkg::CFG_RST;
      fld_q <= slc_pkg::CFG_RST;
      ilk_q <= slc_pkg::CFG_RST;
      dlk_q <= slc_pkg::CFG_RST;
    end else begin
      fli_q <= (cfg_wr && wb_dat_i[slc_pkg::CFG_IFLUSH]) ||
        (fli_q && !fl_go);
      fld_q <= (cfg_wr && wb_dat_i[slc_pkg::CFG_DFLUSH]) ||
        (fld_q && !fl_go);
      if (cfg_wr) begin
        ilk_q <= wb_dat_i[slc_pkg::CFG_ILOCK];
        dlk_q <= wb_dat_i[slc_pkg::CFG_DLOCK];
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/slc_top_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module slc_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire slc_pkg::slc_ls_req_t ls_req_i,
  input wire logic ls_ack_o,
  input wire logic [63:0] ls_rdat_o,
  input wire slc_pkg::slc_if_req_t if_req_i,
  input wire slc_pkg::slc_snp_t snp_i,
  input wire logic snp_done_o,
  input wire slc_pkg::slc_nl_req_t nl_req_o,
  input wire logic l2_miss_i,
  input wire logic fill_vld_i,
  input wire logic [63:0] fill_dat_i,
  input wire logic cb_vld_o,
  input wire logic [31:0] cb_adr_o,
  input wire logic cb_rdy_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // beats seen in the current refill
  logic [2:0] beats_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !nl_req_o.vld) beats_q <= 3'h0;
    else if (fill_vld_i) beats_q <= beats_q + 3'h1;
  end
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wb ack");
  property p_l2_first;
    $rose(nl_req_o.vld) |-> !nl_req_o.bus;
  endproperty
  a_l2_first: assert property (p_l2_first) else $error("bus first");
  property p_bus_after;
    nl_req_o.vld && $rose(nl_req_o.bus) |-> $past(l2_miss_i) ||
      $past(l2_miss_i, 2);
  endproperty
  a_bus_after: assert property (p_bus_after) else $error("bus");
  property p_crit_adr;
    $rose(nl_req_o.vld) && $past(ls_req_i.vld) |->
      nl_req_o.adr == {$past(ls_req_i.pa[31:3]), 3'h0};
  endproperty
  a_crit_adr: assert property (p_crit_adr) else $error("adr");
  property p_rwitm;
    nl_req_o.vld && ls_req_i.vld && !if_req_i.vld |-> nl_req_o.rwitm;
  endproperty
  a_rwitm: assert property (p_rwitm) else $error("rwitm");
  property p_fwd;
    fill_vld_i && beats_q == 3'h0 && ls_req_i.vld && !ls_req_i.we &&
      !if_req_i.vld |=> ls_ack_o && ls_rdat_o == $past(fill_dat_i);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward");
  property p_snp_done;
    snp_i.vld && !snp_done_o && !nl_req_o.vld |-> ##[1:20] snp_done_o;
  endproperty
  a_snp_done: assert property (p_snp_done) else $error("snoop");
  property p_cb_hold;
    cb_vld_o && !cb_rdy_i |=> cb_vld_o && $stable(cb_adr_o);
  endproperty
  a_cb_hold: assert property (p_cb_hold) else $error("cb hold");
  property p_cb_align;
    $rose(cb_vld_o) && snp_done_o |-> cb_adr_o == {snp_i.pa[31:5], 5'h00};
  endproperty
  a_cb_align: assert property (p_cb_align) else $error("cb adr");
endmodule
bind slc_top slc_top_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .ls_req_i(ls_req_i), .ls_ack_o(ls_ack_o), .ls_rdat_o(ls_rdat_o),
  .if_req_i(if_req_i), .snp_i(snp_i), .snp_done_o(snp_done_o),
  .nl_req_o(nl_req_o), .l2_miss_i(l2_miss_i), .fill_vld_i(fill_vld_i),
  .fill_dat_i(fill_dat_i), .cb_vld_o(cb_vld_o), .cb_adr_o(cb_adr_o),
  .cb_rdy_i(cb_rdy_i));
`default_nettype wire

// *** testbench/slc_nl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module slc_nl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire slc_pkg::slc_nl_req_t nl_req_i,
  input wire logic cb_vld_i,
  output logic l2_hit_o,
  output logic l2_miss_o,
  output logic fill_vld_o,
  output logic [63:0] fill_dat_o,
  output logic cb_rdy_o
);
  logic [2:0] st_q;
  logic [1:0] beat_q;
  logic [31:0] a;
  // beats wrap from the critical double word
  always_comb a = {nl_req_i.adr[31:5], nl_req_i.adr[4:3] + beat_q, 3'h0};
  always_ff @(posedge clk_i) begin
    l2_hit_o <= 1'b0;
    l2_miss_o <= 1'b0;
    fill_vld_o <= 1'b0;
    fill_dat_o <= ~fill_dat_o; // no stale data between beats
    cb_rdy_o <= cb_vld_i && !cb_rdy_o; // stalls each copy-back a cycle
    if (rst_i) begin
      st_q <= 3'h0;
      beat_q <= 2'h0;
      cb_rdy_o <= 1'b0;
      fill_dat_o <= 64'h0;
    end else begin
      case (st_q)
        3'h0: if (nl_req_i.vld && !nl_req_i.bus) st_q <= 3'h1;
        3'h1: st_q <= 3'h2; // slow level-two lookup
        3'h2: begin
          l2_hit_o <= nl_req_i.adr[12];
          l2_miss_o <= !nl_req_i.adr[12];
          st_q <= 3'h3;
        end
        3'h3: if (nl_req_i.bus || nl_req_i.adr[12]) st_q <= 3'h4;
        3'h4: begin
          fill_vld_o <= 1'b1;
          fill_dat_o <= {a[31:3], 3'h0, ~a[31:3], 3'h7};
          beat_q <= beat_q + 2'h1;
          if (beat_q == 2'h3) st_q <= 3'h5;
        end
        default: if (!nl_req_i.vld) st_q <= 3'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/slc_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module slc_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ls_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, cb_adr_o, nl_adr;
  slc_pkg::slc_ls_req_t ls_req_i;
  slc_pkg::slc_if_req_t if_req_i;
  slc_pkg::slc_snp_t snp_i;
  slc_pkg::slc_nl_req_t nl_req_o;
  logic [63:0] ls_rdat_o, fill_dat_i, rd, e;
  logic [127:0] if_dat_o;
  logic [255:0] cb_dat_o;
  logic if_ack_o, snp_done_o, snp_hit_o, l2_hit_i, l2_miss_i, fill_vld_i;
  logic cb_vld_o, cb_rdy_i;
  int failures, checks;
  slc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ls_req_i(ls_req_i), .ls_ack_o(ls_ack_o),
    .ls_rdat_o(ls_rdat_o), .if_req_i(if_req_i), .if_ack_o(if_ack_o),
    .if_dat_o(if_dat_o), .snp_i(snp_i), .snp_done_o(snp_done_o),
    .snp_hit_o(snp_hit_o), .nl_req_o(nl_req_o), .l2_hit_i(l2_hit_i),
    .l2_miss_i(l2_miss_i), .fill_vld_i(fill_vld_i),
    .fill_dat_i(fill_dat_i), .cb_vld_o(cb_vld_o), .cb_adr_o(cb_adr_o),
    .cb_dat_o(cb_dat_o), .cb_rdy_i(cb_rdy_i));
  slc_nl_model i_nl (.clk_i(clk_i), .rst_i(rst_i), .nl_req_i(nl_req_o),
    .cb_vld_i(cb_vld_o), .l2_hit_o(l2_hit_i), .l2_miss_o(l2_miss_i),
    .fill_vld_o(fill_vld_i), .fill_dat_o(fill_dat_i), .cb_rdy_o(cb_rdy_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (nl_req_o.vld) nl_adr = nl_req_o.adr;
  function automatic logic [63:0] dw(input logic [31:0] a);
    return {a[31:3], 3'h0, ~a[31:3], 3'h7};
  endfunction
  task chk(input string n, input logic [255:0] x, input logic [255:0] g);
    checks++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, g);
      failures++;
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // bus tasks: hold until the answer, bounded wait
  // ---------------------------------------------------------------
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    wb_sel_i <= 4'hf;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 99);
    rd = {32'h0, wb_dat_o};
    if (n >= 99) failures++;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  task ls(input logic we, input logic [31:0] a, input logic [7:0] be,
      input logic [63:0] d);
    int n;
    ls_req_i <= {1'b1, we, be, a, a, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ls_ack_o !== 1'b1 && n < 299);
    rd = ls_rdat_o;
    if (n >= 299) failures++;
    ls_req_i <= '0;
    @(posedge clk_i);
  endtask
  task snoop(input logic [4:0] tt, input logic [31:0] a);
    int n;
    snp_i <= {1'b1, 1'b1, tt, a};
    n = 0;
    do begin @(posedge clk_i); n++; end while (snp_done_o !== 1'b1 && n < 99);
    e = {62'h0, snp_hit_o, cb_vld_o};
    if (n >= 99) failures++;
    snp_i <= '0;
    @(posedge clk_i);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    chk("nl_vld", 1'b0, nl_req_o.vld);
    wb(1'b0, 8'h00, 32'h0);
    chk("cfg", 64'h0, rd);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", 64'h0, rd);
    $display("test reset done");
  endtask
  task t_miss(input logic [31:0] a);
    nl_adr = 32'h0;
    ls(1'b0, a, 8'hff, 64'h0);
    chk("crit_adr", {a[31:3], 3'h0}, nl_adr);
    chk("l2_only", 1'b0, nl_req_o.bus);
    chk("miss_dat", dw(a), rd);
    ls(1'b0, a ^ 32'h18, 8'hff, 64'h0);
    chk("hit_dat", dw(a ^ 32'h18), rd);
    $display("test miss done");
  endtask
  task t_store(input logic [31:0] a);
    ls(1'b1, a, 8'h02, 64'h0000_0000_0000_ab00);
    ls(1'b1, a, 8'hf0, 64'h1122_3344_0000_0000);
    ls(1'b0, a, 8'hff, 64'h0);
    e = dw(a);
    e[15:8] = 8'hab;
    e[63:32] = 32'h1122_3344;
    chk("merge", e, rd);
    $display("test store done");
  endtask
  task t_fetch(input logic [31:0] f);
    int n;
    if_req_i <= {1'b1, f, f};
    n = 0;
    do begin @(posedge clk_i); n++; end while (if_ack_o !== 1'b1 && n < 299);
    chk("fetch", {dw(f | 32'h8), dw(f & ~32'h8)}, if_dat_o);
    if_req_i <= '0;
    @(posedge clk_i);
    $display("test fetch done");
  endtask
  task t_snoop(input logic [31:0] a);
    snoop(5'h05, 32'h0bad_0000);
    chk("snp_miss", 64'h0, e);
    snoop(5'h00, a);
    chk("snp_hit", 64'h3, e);
    chk("cb_adr", {a[31:5], 5'h0}, cb_adr_o);
    chk("cb_byte", 8'hab, cb_dat_o[64 * a[4:3] + 8 +: 8]);
    repeat (4) @(posedge clk_i);
    nl_adr = 32'h0;
    ls(1'b0, a, 8'hff, 64'h0);
    chk("refetch", {a[31:3], 3'h0}, nl_adr);
    $display("test snoop done");
  endtask
  task t_inhib(input logic [31:0] a);
    ls(1'b1, a, 8'h02, 64'h0000_0000_0000_cd00);
    snoop(5'h0a, a);
    repeat (4) @(posedge clk_i);
    nl_adr = 32'h0;
    ls(1'b0, a, 8'hff, 64'h0);
    e = dw(a);
    e[15:8] = 8'hcd;
    chk("inhib_keep", e, rd);
    chk("inhib_nl", 32'h0, nl_adr);
    $display("test inhibited done");
  endtask
  task t_flush(input logic [31:0] a);
    wb(1'b1, 8'h00, 32'h2);
    repeat (4) @(posedge clk_i);
    nl_adr = 32'h0;
    ls(1'b0, a, 8'hff, 64'h0);
    chk("flush_miss", {a[31:3], 3'h0}, nl_adr);
    chk("flush_dat", dw(a), rd);
    wb(1'b0, 8'h00, 32'h0);
    chk("cfg_clr", 64'h0, rd);
    $display("test flush done");
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    ls_req_i = '0;
    if_req_i = '0;
    snp_i = '0;
    failures = 0;
    checks = 0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_miss(32'h1234_5650);
    t_store(32'h1234_5650);
    t_fetch(32'h0004_0a30);
    t_fetch(32'h0004_0a20);
    t_snoop(32'h1234_5650);
    t_inhib(32'h1234_5650);
    t_flush(32'h1234_5650);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
